// ===== include/urx_pkg.sv
// constants, register map and types of the receive path with flow control
package urx_pkg;
    // avalon register word byte addresses
    localparam logic [4:0] ADR_RX_DATA   = 5'h00; // receive_buffer_reg, ro
    localparam logic [4:0] ADR_LINE_CTL  = 5'h04; // line_control_reg, rw
    localparam logic [4:0] ADR_MODEM_CTL = 5'h08; // modem_control_reg, rw
    localparam logic [4:0] ADR_LINE_STAT = 5'h0c; // line_status_reg, ro
    localparam logic [4:0] ADR_FIFO_CTL  = 5'h10; // fifo control, rw
    localparam logic [4:0] ADR_DIVISOR   = 5'h14; // 16 bit baud divisor
    localparam logic [4:0] ADR_FLOW_STAT = 5'h18; // flow pin status, ro
    // line_control_reg fields
    localparam int LCR_LEN_LSB    = 0;  // char_len_bit0
    localparam int LCR_PAR_EN     = 3;  // parity_enable_bit
    localparam int LCR_PAR_EVEN   = 4;  // parity_even_bit
    // modem_control_reg fields
    localparam int MCR_RTS        = 1;  // request-to-send bit
    localparam int MCR_AUTOFLOW   = 5;  // autoflow_enable_bit
    // line_status_reg fields
    localparam int LSR_DR         = 0;  // data_ready_flag
    localparam int LSR_OE         = 1;  // overrun_flag
    localparam int LSR_PE         = 2;  // parity_error_flag
    localparam int LSR_FE         = 3;  // framing_error_flag
    localparam int LSR_BI         = 4;  // break indication
    // fifo control fields
    localparam int FCR_EN         = 0;  // fifo mode enable
    localparam int FCR_RX_CLR     = 1;  // receive fifo clear, self clearing
    localparam int FCR_TRIG_LSB   = 6;  // trigger level select
    // trigger level codes and fill levels
    localparam logic [1:0] TRIG_SEL_14 = 2'h3;
    localparam logic [4:0] TRIG_LVL_1  = 5'h01;
    localparam logic [4:0] TRIG_LVL_4  = 5'h04;
    localparam logic [4:0] TRIG_LVL_8  = 5'h08;
    localparam logic [4:0] TRIG_LVL_14 = 5'h0e;
    // sizes and reset values
    localparam int FIFO_DEPTH     = 16;
    localparam logic [4:0] FIFO_FULL_CNT = 5'h10; // fill of a full fifo
    localparam logic [4:0] LAST_SLOT_CNT = 5'h0f; // one slot left
    localparam logic [4:0] ONE_CNT       = 5'h01; // non fifo capacity
    localparam logic [7:0]  LCR_RST = 8'h00;
    localparam logic [7:0]  MCR_RST = 8'h00;
    localparam logic [7:0]  FCR_RST = 8'h00;
    localparam logic [15:0] DIV_RST = 16'h0001;
    // oversampling timing, in 16x clock ticks
    localparam logic [3:0] OVS_HALF = 4'h7;  // eighth tick: bit centre
    localparam logic [3:0] OVS_FULL = 4'hf;  // sixteenth tick: next centre
    localparam logic [2:0] MIN_LEN  = 3'h5;  // shortest character
    // receiver states, gray along idle-start-data-parity-stop
    typedef enum logic [2:0] {
        URX_IDLE  = 3'b000,
        URX_START = 3'b001,
        URX_DATA  = 3'b011,
        URX_PAR   = 3'b010,
        URX_STOP  = 3'b110
    } urx_state_e;
endpackage

// ===== rtl/urx_rx_autoflow.sv
// receive path of one serial channel with automatic rts/cts flow control
`timescale 1ns/1ps
module urx_rx_autoflow
    import urx_pkg::*;
(
    input  wire logic        CLK_SYS_I,          // 50 mhz reference clock
    input  wire logic        ARST_N_I,           // async reset, active low
    input  wire logic [4:0]  AVS_ADDRESS_I,      // byte address
    input  wire logic        AVS_READ_I,         // read request
    input  wire logic        AVS_WRITE_I,        // write request
    input  wire logic [31:0] AVS_WRITEDATA_I,    // write data
    input  wire logic [3:0]  AVS_BYTEENABLE_I,   // byte lanes
    output logic      [31:0] AVS_READDATA_O,     // read data
    output logic             AVS_WAITREQUEST_O,  // stall, high idle
    input  wire logic        SERIAL_IN_PIN_I,    // serial_input_line
    input  wire logic        CTS_N_I,            // clear-to-send, low active
    output logic             RTS_N_O,            // request-to-send, low act
    output logic             TX_PERMIT_O         // transmitter may start
);
    import urx_pkg::*;

    // ---------------- bus slave ----------------
    logic        wait_reg;                 // waitrequest flop
    logic [31:0] rdata_reg;                // read data flop
    logic        acc_done;                 // completing edge of access
    logic        rd_done;                  // completing read
    logic        wr_done;                  // completing write
    logic [7:0]  lcr_reg;                  // line_control_reg
    logic [7:0]  mcr_reg;                  // modem_control_reg
    logic [7:0]  fcr_reg;                  // fifo control
    logic [15:0] div_reg;                  // baud divisor
    logic [4:0]  lsr_flags;                // live line status bits

    assign acc_done = (AVS_READ_I | AVS_WRITE_I) & ~wait_reg;
    assign rd_done  = AVS_READ_I & ~wait_reg;
    assign wr_done  = AVS_WRITE_I & ~wait_reg;

    // one wait cycle per access, so read data is ready when wait drops
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            wait_reg <= 1'b1;
        end else begin
            wait_reg <= ~((AVS_READ_I | AVS_WRITE_I) & wait_reg);
        end
    end

    // control registers on byte lane 0, divisor high byte on lane 1; write takes effect on done
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            lcr_reg <= LCR_RST;
            mcr_reg <= MCR_RST;
            fcr_reg <= FCR_RST;
            div_reg <= DIV_RST;
        end else begin
            fcr_reg[FCR_RX_CLR] <= 1'b0;                 // self clearing
            if (wr_done && AVS_BYTEENABLE_I[0]) begin
                case (AVS_ADDRESS_I)
                    ADR_LINE_CTL:  lcr_reg <= AVS_WRITEDATA_I[7:0];
                    ADR_MODEM_CTL: mcr_reg <= AVS_WRITEDATA_I[7:0];
                    ADR_FIFO_CTL:  fcr_reg <= AVS_WRITEDATA_I[7:0];
                    ADR_DIVISOR:   div_reg[7:0] <= AVS_WRITEDATA_I[7:0];
                    default: ;                           // ignored
                endcase
            end
            if (wr_done && AVS_BYTEENABLE_I[1] &&
                AVS_ADDRESS_I == ADR_DIVISOR) begin
                div_reg[15:8] <= AVS_WRITEDATA_I[15:8];
            end
        end
    end

    // ---------------- receive fifo storage ----------------
    logic [10:0] fifo_mem [FIFO_DEPTH];    // data + pe,fe,bi per char
    logic [3:0]  wr_ptr;                   // write index
    logic [3:0]  rd_ptr;                   // read index
    logic [4:0]  fill_cnt;                 // characters held
    logic        fifo_mode;                // fifo enabled
    logic        fifo_full;                // no room for a character
    logic        push;                     // character finished
    logic        pop;                      // buffer read completes
    logic        overwrite;                // non fifo overrun
    logic [10:0] push_word;                // character with errors

    assign fifo_mode = fcr_reg[FCR_EN];
    assign fifo_full = fifo_mode ? (fill_cnt == FIFO_FULL_CNT)
                                 : (fill_cnt == ONE_CNT);
    assign pop = rd_done && AVS_ADDRESS_I == ADR_RX_DATA &&
                 fill_cnt != 5'h00;
    assign overwrite = push & fifo_full & ~fifo_mode & ~pop;

    // read data latched while waiting, stands at the completing edge
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rdata_reg <= 32'h0000_0000;
        end else if (AVS_READ_I && wait_reg) begin
            case (AVS_ADDRESS_I)
                ADR_RX_DATA:   rdata_reg <= {24'h00_0000,
                                             fifo_mem[rd_ptr][7:0]};
                ADR_LINE_CTL:  rdata_reg <= {24'h00_0000, lcr_reg};
                ADR_MODEM_CTL: rdata_reg <= {24'h00_0000, mcr_reg};
                ADR_LINE_STAT: rdata_reg <= {27'h000_0000, lsr_flags};
                ADR_FIFO_CTL:  rdata_reg <= {24'h00_0000, fcr_reg};
                ADR_DIVISOR:   rdata_reg <= {16'h0000, div_reg};
                ADR_FLOW_STAT: rdata_reg <= {29'h0000_0000, TX_PERMIT_O,
                                             RTS_N_O, ~CTS_N_I};
                default:       rdata_reg <= 32'h0000_0000; // unmapped
            endcase
        end
    end

    // ---------------- baud generator ----------------
    logic [15:0] baud_cnt;                 // divisor count up
    logic        tick16;                   // 16x clock enable pulse

    // reference clock divided by divisor; divisor 0 stops the clock
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            baud_cnt <= 16'h0000;
            tick16   <= 1'b0;
        end else if (div_reg == 16'h0000) begin
            baud_cnt <= 16'h0000;
            tick16   <= 1'b0;
        end else if (baud_cnt >= div_reg - 16'h0001) begin
            baud_cnt <= 16'h0000;
            tick16   <= 1'b1;
        end else begin
            baud_cnt <= baud_cnt + 16'h0001;
            tick16   <= 1'b0;
        end
    end

    // ---------------- receiver sequencer ----------------
    urx_state_e  state;                    // receiver state
    logic        rx_prev;                  // input one clock ago
    logic [3:0]  ovs_cnt;                  // ticks within a bit
    logic [2:0]  bit_idx;                  // data bit number
    logic [7:0]  shift_reg;                // receive_shift_reg
    logic        par_acc;                  // running xor of data
    logic        par_err;                  // parity mismatch seen
    logic [2:0]  char_len_m1;              // data bits minus one
    logic        at_centre;                // this tick is a bit centre
    logic        first_data;               // start verified this clock

    assign char_len_m1 = MIN_LEN - 3'h1 + lcr_reg[LCR_LEN_LSB +: 2];
    assign at_centre  = tick16 && ((state == URX_START) ? ovs_cnt == OVS_HALF
                                                        : ovs_cnt == OVS_FULL);
    assign first_data = state == URX_START && at_centre && !SERIAL_IN_PIN_I;

    // input history for edge detection; pins are synchronous here
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rx_prev <= 1'b1;
        end else begin
            rx_prev <= SERIAL_IN_PIN_I;
        end
    end

    // start search, centre sampling and character assembly
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            state     <= URX_IDLE;
            ovs_cnt   <= 4'h0;
            bit_idx   <= 3'h0;
            shift_reg <= 8'h00;
            par_acc   <= 1'b0;
            par_err   <= 1'b0;
        end else begin
            if (tick16 && state != URX_IDLE) begin
                ovs_cnt <= at_centre ? 4'h0 : ovs_cnt + 4'h1;
            end
            case (state)
                URX_IDLE: begin
                    if (rx_prev && !SERIAL_IN_PIN_I) begin
                        state     <= URX_START;
                        ovs_cnt   <= 4'h0;
                        shift_reg <= 8'h00;
                        par_acc   <= 1'b0;
                        par_err   <= 1'b0;
                        bit_idx   <= 3'h0;
                    end
                end
                URX_START: begin
                    if (at_centre) begin
                        // noise spike: back to searching
                        state <= SERIAL_IN_PIN_I ? URX_IDLE : URX_DATA;
                    end
                end
                URX_DATA: begin
                    if (at_centre) begin
                        shift_reg[bit_idx] <= SERIAL_IN_PIN_I;
                        par_acc <= par_acc ^ SERIAL_IN_PIN_I;
                        bit_idx <= bit_idx + 3'h1;
                        if (bit_idx == char_len_m1) begin
                            state <= lcr_reg[LCR_PAR_EN] ? URX_PAR
                                                         : URX_STOP;
                        end
                    end
                end
                URX_PAR: begin
                    if (at_centre) begin
                        par_err <= par_acc ^ SERIAL_IN_PIN_I ^
                                   ~lcr_reg[LCR_PAR_EVEN];
                        state   <= URX_STOP;
                    end
                end
                URX_STOP: begin
                    if (at_centre) begin
                        state <= URX_IDLE;
                    end
                end
                default: state <= URX_IDLE;
            endcase
        end
    end

    // finished character: data, parity, framing and break bits
    assign push = state == URX_STOP && at_centre;
    assign push_word = {shift_reg == 8'h00 && !SERIAL_IN_PIN_I,     // break
                        !SERIAL_IN_PIN_I,
                        par_err,
                        shift_reg};

    // fifo entries, one generate slot per entry
    for (genvar g = 0; g < FIFO_DEPTH; g++) begin : g_slot
        always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
            if (!ARST_N_I) begin
                fifo_mem[g] <= 11'h000;
            end else if (push && !fifo_full && wr_ptr == 4'(g)) begin
                fifo_mem[g] <= push_word;
            end else if (overwrite && rd_ptr == 4'(g)) begin
                fifo_mem[g] <= push_word;
            end
        end
    end

    // pointers and fill; non fifo mode is a one character buffer
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            wr_ptr   <= 4'h0;
            rd_ptr   <= 4'h0;
            fill_cnt <= 5'h00;
        end else if (fcr_reg[FCR_RX_CLR]) begin
            wr_ptr   <= 4'h0;
            rd_ptr   <= 4'h0;
            fill_cnt <= 5'h00;
        end else begin
            // a pop lets pointers and fill take a push in the same clock, but the slot is written only when not full
            if (push && (!fifo_full || pop)) begin
                wr_ptr <= fifo_mode ? wr_ptr + 4'h1 : rd_ptr;
            end
            if (pop) begin
                rd_ptr <= fifo_mode ? rd_ptr + 4'h1 : rd_ptr;
            end
            case ({push && (!fifo_full || pop), pop})
                2'b10:   fill_cnt <= fill_cnt + 5'h01;
                2'b01:   fill_cnt <= fill_cnt - 5'h01;
                default: fill_cnt <= fill_cnt;
            endcase
        end
    end

    // sticky error bits: cleared by status read, a new set wins
    logic oe_flag;                         // overrun_flag
    logic pe_flag;                         // parity_error_flag
    logic fe_flag;                         // framing_error_flag
    logic bi_flag;                         // break flag
    logic lsr_rd;                          // status read completes

    assign lsr_rd = rd_done && AVS_ADDRESS_I == ADR_LINE_STAT;

    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            oe_flag <= 1'b0;
            pe_flag <= 1'b0;
            fe_flag <= 1'b0;
            bi_flag <= 1'b0;
        end else begin
            oe_flag <= (push && fifo_full && !pop) | (oe_flag & ~lsr_rd);
            pe_flag <= (push && push_word[8])  | (pe_flag & ~lsr_rd);
            fe_flag <= (push && push_word[9])  | (fe_flag & ~lsr_rd);
            bi_flag <= (push && push_word[10]) | (bi_flag & ~lsr_rd);
        end
    end

    assign lsr_flags = {bi_flag, fe_flag, pe_flag, oe_flag,
                        fill_cnt != 5'h00};

    // ---------------- flow control ----------------
    logic        auto_rts;                 // automatic rts active
    logic        auto_cts;                 // automatic cts active
    logic        rts_hold;                 // auto rts currently dropped
    logic [4:0]  trig_lvl;                 // selected trigger fill
    logic        trig14;                   // trigger 14 selected

    assign auto_rts = mcr_reg[MCR_AUTOFLOW] & mcr_reg[MCR_RTS] & fifo_mode;
    assign auto_cts = mcr_reg[MCR_AUTOFLOW] & fifo_mode;
    assign trig14   = fcr_reg[FCR_TRIG_LSB +: 2] == TRIG_SEL_14;

    always_comb begin
        case (fcr_reg[FCR_TRIG_LSB +: 2])
            2'h0:    trig_lvl = TRIG_LVL_1;
            2'h1:    trig_lvl = TRIG_LVL_4;
            2'h2:    trig_lvl = TRIG_LVL_8;
            default: trig_lvl = TRIG_LVL_14;
        endcase
    end

    // rts drop and return; the receiver keeps taking characters meanwhile
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rts_hold <= 1'b0;
        end else if (!auto_rts) begin
            rts_hold <= 1'b0;
        end else if (trig14) begin
            if (first_data && fill_cnt == LAST_SLOT_CNT) begin
                rts_hold <= 1'b1;
            end else if (pop) begin
                rts_hold <= 1'b0;
            end
        end else begin
            if (fill_cnt >= trig_lvl) begin
                rts_hold <= 1'b1;
            end else if (fill_cnt == 5'h00) begin
                rts_hold <= 1'b0;
            end
        end
    end

    // pin drivers; cts changes only gate the transmitter, no interrupt
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            RTS_N_O     <= 1'b1;
            TX_PERMIT_O <= 1'b1;
        end else begin
            RTS_N_O     <= ~(mcr_reg[MCR_RTS] & ~rts_hold);
            TX_PERMIT_O <= ~auto_cts | ~CTS_N_I;
        end
    end

    assign AVS_READDATA_O    = rdata_reg;
    assign AVS_WAITREQUEST_O = wait_reg;

    // ---------------- assertions ----------------
    a_start_noise: assert property (@(posedge CLK_SYS_I)
        disable iff (!ARST_N_I)
        (state == URX_START && at_centre && SERIAL_IN_PIN_I)
            |=> state == URX_IDLE)
        else $error("noise start not rejected");

    a_edge_starts: assert property (@(posedge CLK_SYS_I)
        disable iff (!ARST_N_I)
        (state == URX_IDLE && rx_prev && !SERIAL_IN_PIN_I)
            |=> state == URX_START && ovs_cnt == 4'h0)
        else $error("falling edge missed");

    a_ready_set: assert property (@(posedge CLK_SYS_I)
        disable iff (!ARST_N_I)
        (push && !fcr_reg[FCR_RX_CLR]) |=> lsr_flags[LSR_DR])
        else $error("data ready not set");

    a_overrun_set: assert property (@(posedge CLK_SYS_I)
        disable iff (!ARST_N_I)
        (push && fifo_full && !pop) |=> oe_flag)
        else $error("overrun not flagged");

    a_read_clears: assert property (@(posedge CLK_SYS_I)
        disable iff (!ARST_N_I)
        (!fifo_mode && pop && !push && !fcr_reg[FCR_RX_CLR])
            |=> !lsr_flags[LSR_DR])
        else $error("buffer read left data ready");

    a_rts_trig: assert property (@(posedge CLK_SYS_I)
        disable iff (!ARST_N_I)
        (auto_rts && !trig14 && fill_cnt >= trig_lvl) ##1 auto_rts
            |=> RTS_N_O)
        else $error("rts not dropped at trigger");

    a_rts_empty: assert property (@(posedge CLK_SYS_I)
        disable iff (!ARST_N_I)
        (auto_rts && !trig14 && rts_hold && fill_cnt != 5'h00)
            |=> rts_hold)
        else $error("rts returned before empty");

    a_cts_gate: assert property (@(posedge CLK_SYS_I)
        disable iff (!ARST_N_I)
        (auto_cts && CTS_N_I) |=> !TX_PERMIT_O)
        else $error("transmit permitted without cts");

    a_wait_one: assert property (@(posedge CLK_SYS_I)
        disable iff (!ARST_N_I)
        (AVS_READ_I && wait_reg) |=> !AVS_WAITREQUEST_O ##1 wait_reg)
        else $error("waitrequest sequence wrong");
endmodule // urx_rx_autoflow

// ===== testbench/urx_remote.sv
// remote serial sender model that honours request-to-send
`timescale 1ns/1ps
module urx_remote (
    input  wire logic clk_i,   // bit timing reference
    input  wire logic rts_n_i, // receiver ready, active low
    input  wire logic obey_i,  // wait for rts before a char
    output logic      line_o   // serial line, idles high
);
    initial line_o = 1'b1;
    // frame goes out lsb first, w clocks a bit, then back to idle
    task automatic send(input logic [11:0] f, input int n, input int w);
        int k;
        k = 0;
        // with obey_i set, a char waits for rts to be active; bounded wait
        while (obey_i && rts_n_i !== 1'b0 && k < 4000) begin
            @(posedge clk_i);
            k++;
        end
        // rts never came back: count it against the run
        if (k >= 4000) urx_rx_autoflow_bench.err_count++;
        for (int i = 0; i < n; i++) begin
            line_o <= f[i];
            repeat (w) @(posedge clk_i);
        end
        line_o <= 1'b1;
        // one idle clock so the next frame never lands in this step
        @(posedge clk_i);
    endtask
endmodule // urx_remote

// ===== testbench/urx_rx_autoflow_bench.sv
// self-checking bench of the receive path with flow control
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
    err_count++; $display("FAIL t=%0t got %h exp %h", $time, a, b); end end
module urx_rx_autoflow_bench;
    import urx_pkg::*;
    logic        clk = 1'b0;    // 50 mhz system clock
    logic        rst_n = 1'b0;  // async reset, active low
    logic [4:0]  adr = 5'h00;   // bus address
    logic        rd = 1'b0;     // read strobe
    logic        wr = 1'b0;     // write strobe
    logic [31:0] wd = 32'h0;    // write data
    logic [31:0] rdat;          // read data
    logic [31:0] q;             // last value read
    logic        wq;            // waitrequest
    logic        line;          // serial line from the remote
    logic        cts_n = 1'b0;  // clear-to-send into the block
    logic        rts_n;         // request-to-send out of the block
    logic        permit;        // transmitter start permit
    logic        obey = 1'b0;   // remote honours rts
    int          err_count = 0;
    int          total_checks = 0;
    always #10 clk = ~clk;
    urx_rx_autoflow urx_rx_autoflow_i (.CLK_SYS_I(clk), .ARST_N_I(rst_n),
        .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
        .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(4'h3),
        .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wq),
        .SERIAL_IN_PIN_I(line), .CTS_N_I(cts_n), .RTS_N_O(rts_n),
        .TX_PERMIT_O(permit));
    urx_remote urx_remote_i (.clk_i(clk), .rts_n_i(rts_n), .obey_i(obey),
        .line_o(line));
    // verdict and end of run
    task automatic end_of_test();
        if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one avalon access; held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [7:0] d);
        int k;
        k = 0;
        adr <= a;
        wd <= {24'h0, d};
        rd <= !w;
        wr <= w;
        do begin @(posedge clk); k++; end while (wq !== 1'b0 && k < 20);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
        if (k >= 20) begin err_count++; end_of_test(); end
    endtask
    task automatic rc(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 8'h00);
        `CHK(q, e)
    endtask
    // 8 data bits, no parity, chosen stop level
    function automatic logic [11:0] c8(input logic [7:0] d, input logic s);
        return {3'b000, s, d, 1'b0};
    endfunction
    initial begin
        repeat (30000) @(posedge clk);
        err_count++;
        end_of_test();
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        `CHK({rts_n, permit}, 2'b11)
        rc(ADR_MODEM_CTL, 32'h0);
        rc(ADR_DIVISOR, 32'h1);
        rc(5'h1c, 32'h0);
        urx_remote_i.send(12'h06a, 7, 16);
        rc(ADR_LINE_STAT, 32'h1);
        rc(ADR_RX_DATA, 32'h15);
        rc(ADR_LINE_STAT, 32'h0);
        bus(1'b1, ADR_LINE_CTL, 8'h03);
        // glitch shorter than half a bit must be dropped
        urx_remote_i.send(12'h000, 1, 4);
        repeat (300) @(posedge clk);
        rc(ADR_LINE_STAT, 32'h0);
        bus(1'b1, ADR_DIVISOR, 8'h02);
        urx_remote_i.send(c8(8'h5a, 1'b1), 10, 32);
        rc(ADR_RX_DATA, 32'h5a);
        bus(1'b1, ADR_DIVISOR, 8'h01);
        urx_remote_i.send(c8(8'ha5, 1'b1), 10, 16);
        urx_remote_i.send(c8(8'h3c, 1'b1), 10, 16);
        rc(ADR_LINE_STAT, 32'h3);
        rc(ADR_RX_DATA, 32'h3c);
        urx_remote_i.send(c8(8'h55, 1'b0), 10, 16);
        rc(ADR_LINE_STAT, 32'h9);
        rc(ADR_RX_DATA, 32'h55);
        // same frame, parity bit 0: wrong for even, right for odd
        for (int i = 0; i < 2; i++) begin
            bus(1'b1, ADR_LINE_CTL, i ? 8'h0b : 8'h1b);
            urx_remote_i.send({2'b10, 8'h01, 1'b0}, 11, 16);
            rc(ADR_LINE_STAT, i ? 32'h1 : 32'h5);
            rc(ADR_RX_DATA, 32'h1);
        end
        bus(1'b1, ADR_LINE_CTL, 8'h03);
        bus(1'b1, ADR_FIFO_CTL, 8'h03);
        bus(1'b1, ADR_MODEM_CTL, 8'h22);
        // pin flop follows the modem register one clock later
        @(posedge clk);
        `CHK(rts_n, 1'b0)
        obey = 1'b1;
        urx_remote_i.send(c8(8'h11, 1'b1), 10, 16);
        obey = 1'b0;
        urx_remote_i.send(c8(8'h22, 1'b1), 10, 16);
        `CHK(rts_n, 1'b1)
        rc(ADR_RX_DATA, 32'h11);
        `CHK(rts_n, 1'b1)
        rc(ADR_RX_DATA, 32'h22);
        repeat (2) @(posedge clk);
        `CHK(rts_n, 1'b0)
        cts_n <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK(permit, 1'b0)
        cts_n <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK(permit, 1'b1)
        bus(1'b1, ADR_MODEM_CTL, 8'h20);
        cts_n <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK({rts_n, permit}, 2'b10)
        rc(ADR_FLOW_STAT, 32'h2);
        end_of_test();
    end
endmodule // urx_rx_autoflow_bench
